// [verilog/dop_pkg.sv]
package dop_pkg;
  // ---------------------------------------------------------------
  // address and frame layout
  // ---------------------------------------------------------------
  localparam logic [4:0] DOP_ADDR_FIXED_HI = 5'h0b;
  localparam logic [1:0] DOP_ADDR_FIXED_LO = 2'h3;
  localparam int DOP_BITS_PER_BYTE = 8;
  localparam logic [3:0] DOP_BIT_CNT_ACK = 4'h8;
  localparam logic [3:0] DOP_BIT_CNT_ONE = 4'h1;
  // ---------------------------------------------------------------
  // instruction byte fields
  // ---------------------------------------------------------------
  localparam int DOP_INS_CHAN = 7;
  localparam int DOP_INS_SHDN = 6;
  localparam int DOP_INS_FUSE = 5;
  localparam int DOP_INS_OVR = 3;
  // ---------------------------------------------------------------
  // reset values and fuse status
  // ---------------------------------------------------------------
  localparam logic [7:0] DOP_WIPER_MID = 8'h80;
  localparam logic [1:0] DOP_FUSE_READY = 2'h0;
  localparam logic [1:0] DOP_FUSE_FATAL = 2'h2;
  localparam logic [1:0] DOP_FUSE_DONE = 2'h3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int DOP_CLK_MHZ = 200;
  localparam int DOP_FUSE_TIME_MS = 400;
  localparam longint DOP_FUSE_CYCLES = longint'(DOP_FUSE_TIME_MS) * 1000 * DOP_CLK_MHZ;

  typedef enum logic [2:0] {
    DOP_ST_IDLE = 3'b000,
    DOP_ST_ADDR = 3'b001,
    DOP_ST_INSTR = 3'b010,
    DOP_ST_WDATA = 3'b011,
    DOP_ST_RDATA = 3'b100,
    DOP_ST_IGNORE = 3'b101
  } dop_state_t;
endpackage

// [verilog/dop_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module dop_sync
  import dop_pkg::*;
(
  input wire logic mclk_i, // system clock
  input wire logic sys_rst_i, // sync reset
  input wire logic async_i, // pin level
  output logic sync_o, // synchronised level
  output logic rise_o, // one-cycle rise pulse
  output logic fall_o // one-cycle fall pulse
);
  logic meta_reg, sync_reg, last_reg;
  logic meta_next, sync_next, last_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  // idle bus is high, so reset to high to avoid a false edge
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign sync_o = sync_reg;
  assign rise_o = sync_reg & ~last_reg;
  assign fall_o = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// [verilog/dop_fuse_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module dop_fuse_timer
  import dop_pkg::*;
#(
  parameter longint CYCLES = DOP_FUSE_CYCLES
) (
  input wire logic mclk_i, // system clock
  input wire logic sys_rst_i, // sync reset
  input wire logic start_i, // begin programming
  output logic busy_o, // programming in progress
  output logic done_o // one-cycle end pulse
);
  logic [31:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (!busy_reg && start_i) begin
      busy_next = 1'b1;
      cnt_next = 32'(CYCLES - 1);
    end else if (busy_reg) begin
      if (cnt_reg == 32'h0) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 32'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 32'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
endmodule
`default_nettype wire

// [verilog/dop_pot_slave.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - falling data while clock high starts a transfer.
// - first byte is address plus direction; two bits may come from pins.
// - on address match drive ack low on ninth pulse; else ignore transfer.
// - direction bit high means read, low means write.
// - write instruction msb selects channel 1 (low) or 2 (high).
// - shutdown opens A, wiper to B; register kept and still writable.
// - fuse bit programs fuses with stored wiper; takes 400 ms.
// - override lets writes after fuse; clearing restores earlier position.
// - override lost at power-up; wiper presets to midscale or fused value.
// - low instruction bits are ignored.
// - after instruction ack, data byte sets selected wiper; 8 bits plus ack.
// - data changes only while clock low, except start and stop.
// - read sends wiper byte right after address ack.
// - read returns channel last selected by a write instruction.
// - address plus instruction alone retargets reads, wiper unchanged.
// - read sends fuse status byte after data byte.
// - rising data while clock high stops the transfer.
// - further write data bytes update the wiper again.
// - repeated reads send the wiper value again.
// - fuse status 00 ready, 10 fatal, 11 programmed.
// - shutdown never changes the wiper register.
module dop_pot_slave
  import dop_pkg::*;
#(
  parameter bit PIN_ADDR = 1'b1,
  parameter longint FUSE_CYCLES = DOP_FUSE_CYCLES
) (
  input wire logic mclk_i, // system clock
  input wire logic sys_rst_i, // sync reset, acts as power-up
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // data drive value, always low
  output logic sda_oe_o, // data drive enable
  input wire logic addr_select_pin_low_i, // address pin 0
  input wire logic addr_select_pin_high_i, // address pin 1
  input wire logic fuse_blown_i, // fuse array reports blown
  input wire logic fuse_fault_i, // fuse array reports partial blow
  input wire logic [7:0] fused_wiper1_i, // wiper value burnt into fuses, ch 1
  input wire logic [7:0] fused_wiper2_i, // wiper value burnt into fuses, ch 2
  output logic [7:0] wiper_setting1_o, // applied wiper, ch 1
  output logic [7:0] wiper_setting2_o, // applied wiper, ch 2
  output logic shutdown_o, // A open, wiper tied to B
  output logic fuse_prog_o, // fuse programming active
  output logic [1:0] fuse_status_o // fuse status
);
  logic scl_s, scl_rise, scl_fall, sda_s, sda_rise, sda_fall;
  logic fuse_busy, fuse_done;

  dop_sync u_scl (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(scl_i),
    .sync_o(scl_s), .rise_o(scl_rise), .fall_o(scl_fall)
  );
  dop_sync u_sda (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(sda_i),
    .sync_o(sda_s), .rise_o(sda_rise), .fall_o(sda_fall)
  );

  // ---------------------------------------------------------------
  // protocol state
  // ---------------------------------------------------------------
  dop_state_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic ack_reg, ack_next;
  logic drv_reg, drv_next;
  logic rd_idx_reg, rd_idx_next;
  logic chan_reg, chan_next;
  logic [7:0] w1_reg, w1_next, w2_reg, w2_next;
  logic [7:0] keep1_reg, keep1_next, keep2_reg, keep2_next;
  logic ovr_reg, ovr_next;
  logic sd_reg, sd_next;
  logic fstart_reg, fstart_next;
  logic init_reg, init_next;
  logic [7:0] o1_reg, o1_next, o2_reg, o2_next;
  logic [1:0] fs_reg, fs_next;

  // ---------------------------------------------------------------
  // address straps
  // ---------------------------------------------------------------
  logic [1:0] pin_meta_reg, pin_meta_next, pin_sync_reg, pin_sync_next;

  logic start_cond, stop_cond, addr_hit, locked;
  logic [6:0] my_addr;
  logic [7:0] rbyte, sel_w;

  always_comb begin
    my_addr = PIN_ADDR ? {DOP_ADDR_FIXED_HI, pin_sync_reg}
                       : {DOP_ADDR_FIXED_HI, DOP_ADDR_FIXED_LO};
    start_cond = scl_s & sda_fall;
    stop_cond = scl_s & sda_rise;
    addr_hit = (sh_reg[7:1] == my_addr);
    locked = fuse_blown_i & ~ovr_reg;
    sel_w = chan_reg ? w2_reg : w1_reg;
    rbyte = rd_idx_reg ? {fs_reg, 6'h00} : sel_w;
  end

  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    ack_next = ack_reg;
    drv_next = drv_reg;
    rd_idx_next = rd_idx_reg;
    chan_next = chan_reg;
    w1_next = w1_reg;
    w2_next = w2_reg;
    keep1_next = keep1_reg;
    keep2_next = keep2_reg;
    ovr_next = ovr_reg;
    sd_next = sd_reg;
    fstart_next = 1'b0;
    init_next = 1'b0;
    // preset once after reset, override cleared
    if (init_reg) begin
      w1_next = fuse_blown_i ? fused_wiper1_i : DOP_WIPER_MID;
      w2_next = fuse_blown_i ? fused_wiper2_i : DOP_WIPER_MID;
    end
    if (start_cond) begin
      st_next = DOP_ST_ADDR;
      bit_next = 4'h0;
      ack_next = 1'b0;
      drv_next = 1'b0;
    end else if (stop_cond) begin
      st_next = DOP_ST_IDLE;
      drv_next = 1'b0;
    end else if (st_reg != DOP_ST_IDLE && st_reg != DOP_ST_IGNORE && scl_rise) begin
      // sample on rising clock; data is stable while high
      if (!ack_reg && st_reg != DOP_ST_RDATA) begin
        sh_next = {sh_reg[6:0], sda_s};
      end
      if (ack_reg && st_reg == DOP_ST_RDATA) begin
        // nack ends the read, ack asks for another byte
        if (sda_s) st_next = DOP_ST_IGNORE;
      end
      // in a read the count moves on the falling clock only
      if (!ack_reg && st_reg != DOP_ST_RDATA) bit_next = bit_reg + DOP_BIT_CNT_ONE;
    end else if (st_reg != DOP_ST_IDLE && st_reg != DOP_ST_IGNORE && scl_fall) begin
      // drive changes only after falling clock
      if (!ack_reg && bit_reg == DOP_BIT_CNT_ACK) begin
        ack_next = 1'b1;
        bit_next = 4'h0;
        case (st_reg)
          DOP_ST_ADDR: begin
            if (addr_hit) begin
              drv_next = 1'b1;
            end else begin
              st_next = DOP_ST_IGNORE;
              ack_next = 1'b0;
            end
          end
          DOP_ST_INSTR: begin
            drv_next = 1'b1;
            chan_next = sh_reg[DOP_INS_CHAN];
            sd_next = sh_reg[DOP_INS_SHDN];
            // low bits and the zero bit are not looked at
            if (sh_reg[DOP_INS_OVR] && !ovr_reg) begin
              keep1_next = w1_reg;
              keep2_next = w2_reg;
            end
            if (!sh_reg[DOP_INS_OVR] && ovr_reg) begin
              w1_next = keep1_reg;
              w2_next = keep2_reg;
            end
            ovr_next = sh_reg[DOP_INS_OVR];
            fstart_next = sh_reg[DOP_INS_FUSE] & ~fuse_blown_i;
          end
          DOP_ST_WDATA: begin
            drv_next = 1'b1;
            // updates allowed in shutdown
            if (!locked && !fuse_busy) begin
              if (chan_reg) w2_next = sh_reg;
              else w1_next = sh_reg;
            end
          end
          default: begin
            drv_next = 1'b0;
          end
        endcase
      end else if (ack_reg) begin
        ack_next = 1'b0;
        drv_next = 1'b0;
        case (st_reg)
          DOP_ST_ADDR: begin
            if (sh_reg[0]) begin
              st_next = DOP_ST_RDATA;
              rd_idx_next = 1'b0;
              // every read opens with the wiper, whatever the last read left
              drv_next = ~sel_w[7];
              bit_next = 4'h1;
            end else begin
              st_next = DOP_ST_INSTR;
            end
          end
          DOP_ST_INSTR: st_next = DOP_ST_WDATA;
          DOP_ST_RDATA: begin
            // then status, then wiper again
            rd_idx_next = ~rd_idx_reg;
            drv_next = rd_idx_reg ? ~sel_w[7] : ~fs_reg[1];
            bit_next = 4'h1;
          end
          default: st_next = st_reg;
        endcase
      end else if (st_reg == DOP_ST_RDATA) begin
        if (bit_reg == DOP_BIT_CNT_ACK) begin
          drv_next = 1'b0; // release for master ack
          ack_next = 1'b1;
        end else begin
          drv_next = ~rbyte[3'(7 - bit_reg)];
          bit_next = bit_reg + DOP_BIT_CNT_ONE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs: applied wipers follow the wiper registers, also in shutdown
  // ---------------------------------------------------------------
  always_comb begin
    o1_next = w1_reg;
    o2_next = w2_reg;
    // straps are pins, so they cross two flops before the compare
    pin_meta_next = {addr_select_pin_high_i, addr_select_pin_low_i};
    pin_sync_next = pin_meta_reg;
    if (fuse_fault_i) fs_next = DOP_FUSE_FATAL;
    else if (fuse_blown_i) fs_next = DOP_FUSE_DONE;
    else fs_next = DOP_FUSE_READY;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg <= DOP_ST_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ack_reg <= 1'b0;
      drv_reg <= 1'b0;
      rd_idx_reg <= 1'b0;
      chan_reg <= 1'b0;
      w1_reg <= DOP_WIPER_MID;
      w2_reg <= DOP_WIPER_MID;
      keep1_reg <= DOP_WIPER_MID;
      keep2_reg <= DOP_WIPER_MID;
      ovr_reg <= 1'b0;
      sd_reg <= 1'b0;
      fstart_reg <= 1'b0;
      init_reg <= 1'b1;
      o1_reg <= DOP_WIPER_MID;
      o2_reg <= DOP_WIPER_MID;
      fs_reg <= DOP_FUSE_READY;
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      ack_reg <= ack_next;
      drv_reg <= drv_next;
      rd_idx_reg <= rd_idx_next;
      chan_reg <= chan_next;
      w1_reg <= w1_next;
      w2_reg <= w2_next;
      keep1_reg <= keep1_next;
      keep2_reg <= keep2_next;
      ovr_reg <= ovr_next;
      sd_reg <= sd_next;
      fstart_reg <= fstart_next;
      init_reg <= init_next;
      o1_reg <= o1_next;
      o2_reg <= o2_next;
      fs_reg <= fs_next;
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  dop_fuse_timer #(.CYCLES(FUSE_CYCLES)) u_fuse (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .start_i(fstart_reg),
    .busy_o(fuse_busy), .done_o(fuse_done)
  );

  logic fp_reg;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) fp_reg <= 1'b0;
    else fp_reg <= fuse_busy & ~fuse_done;
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = drv_reg;
  assign wiper_setting1_o = o1_reg;
  assign wiper_setting2_o = o2_reg;
  assign shutdown_o = sd_reg;
  assign fuse_prog_o = fp_reg;
  assign fuse_status_o = fs_reg;
endmodule
`default_nettype wire

// [dv/dop_pot_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module dop_pot_monitor
  import dop_pkg::*;
#(
  parameter longint FUSE_CYCLES = DOP_FUSE_CYCLES
) (
  input wire logic mclk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic scl_i, // serial clock
  input wire logic sda_o, // drive value
  input wire logic sda_oe_o, // drive enable
  input wire logic fuse_blown_i, // fuses blown
  input wire logic fuse_fault_i, // partial blow
  input wire logic [7:0] wiper_setting1_o, // wiper 1
  input wire logic [7:0] wiper_setting2_o, // wiper 2
  input wire logic shutdown_o, // shutdown
  input wire logic fuse_prog_o, // programming
  input wire logic [1:0] fuse_status_o // status
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ----
  // programming length
  // ----
  longint prog_cnt_reg;
  longint prog_cnt_next;
  always_comb begin
    prog_cnt_next = fuse_prog_o ? prog_cnt_reg + 1 : 0;
  end
  always_ff @(posedge mclk_i) begin
    prog_cnt_reg <= sys_rst_i ? 0 : prog_cnt_next;
  end
  // ----
  // checks
  // ----
  reset_preset_a:
    assert property ($fell(sys_rst_i) |-> wiper_setting1_o == DOP_WIPER_MID &&
      wiper_setting2_o == DOP_WIPER_MID && !shutdown_o && !fuse_prog_o)
      else $error("outputs not preset after reset");
  drive_low_a:
    assert property (sda_oe_o |-> !sda_o) else $error("data drive not low");
  change_scl_low_a:
    assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved with clock high");
  ack_hold_a:
    assert property ($rose(sda_oe_o) |=> sda_oe_o [*8]) else $error("data drive too short");
  status_code_a:
    assert property ($stable({fuse_blown_i, fuse_fault_i}) [*3] |-> fuse_status_o ==
      (fuse_fault_i ? DOP_FUSE_FATAL : fuse_blown_i ? DOP_FUSE_DONE : DOP_FUSE_READY))
      else $error("fuse status wrong");
  shutdown_keep_a:
    assert property ($changed(shutdown_o) |-> $stable(wiper_setting1_o) &&
      $stable(wiper_setting2_o)) else $error("shutdown moved a wiper");
  prog_freeze_a:
    assert property (fuse_prog_o && $past(fuse_prog_o) |-> $stable(wiper_setting1_o) &&
      $stable(wiper_setting2_o)) else $error("wiper moved while programming");
  prog_length_a:
    assert property ($fell(fuse_prog_o) |-> prog_cnt_reg >= FUSE_CYCLES - 1 &&
      prog_cnt_reg <= FUSE_CYCLES + 1) else $error("programming time wrong");
  prog_bound_a:
    assert property (prog_cnt_reg <= FUSE_CYCLES + 1) else $error("programming overran");
  prog_once_a:
    assert property ($rose(fuse_prog_o) |-> !fuse_blown_i) else $error("blown part reprogrammed");
  ack_seen_c: cover property ($rose(sda_oe_o));
  prog_seen_c: cover property ($fell(fuse_prog_o));
  shutdown_seen_c: cover property ($rose(shutdown_o));
endmodule
`default_nettype wire

// [dv/dop_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module dop_bus_master (
  input wire logic mclk_i, // bench clock
  input wire logic sda_i, // resolved data line
  output logic scl_o, // serial clock, idles high
  output logic pull_o // high pulls data low
);
  // ----
  // bit level, 16 clocks a half period
  // ----
  localparam int Q = 8;
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic bit_cycle(input logic b, output logic r);
    scl_o = 1'b0;
    tick(Q);
    pull_o = !b;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    r = sda_i;
    tick(Q);
  endtask
  task automatic start();
    pull_o = 1'b1;
    tick(2 * Q);
  endtask
  // low before the last pulse, then released with clock high
  task automatic stop();
    scl_o = 1'b0;
    tick(Q);
    pull_o = 1'b1;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    pull_o = 1'b0;
    tick(2 * Q);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], r);
    bit_cycle(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      b[i] = r;
    end
    bit_cycle(!ack, r);
  endtask
endmodule
`default_nettype wire

// [dv/dop_pot_slave_test.sv]
`timescale 1ns/1ps
`default_nettype none
module dop_pot_slave_test;
  import dop_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl_i, sda_i, sda_o, sda_oe_o, m_pull, shutdown_o, fuse_prog_o;
  logic addr_select_pin_low_i = 1'b0;
  logic addr_select_pin_high_i = 1'b0;
  logic fuse_blown_i = 1'b0;
  logic fuse_fault_i = 1'b0;
  logic [7:0] fused_wiper1_i = 8'h00;
  logic [7:0] fused_wiper2_i = 8'h00;
  logic [7:0] wiper_setting1_o, wiper_setting2_o;
  logic [1:0] fuse_status_o;
  logic [6:0] addr;
  logic seen_prog = 1'b0;
  int fails = 0;
  int checks_done = 0;
  always #2.5 mclk_i = ~mclk_i;
  // open drain with pull-up
  assign sda_i = !(m_pull || (sda_oe_o && !sda_o));
  always @(posedge mclk_i) if (fuse_prog_o) seen_prog <= 1'b1;
  dop_bus_master m (.mclk_i, .sda_i, .scl_o(scl_i), .pull_o(m_pull));
  dop_pot_slave #(.PIN_ADDR(1'b1), .FUSE_CYCLES(100)) dut (.mclk_i, .sys_rst_i, .scl_i,
    .sda_i, .sda_o, .sda_oe_o, .addr_select_pin_low_i, .addr_select_pin_high_i,
    .fuse_blown_i, .fuse_fault_i, .fused_wiper1_i, .fused_wiper2_i, .wiper_setting1_o,
    .wiper_setting2_o, .shutdown_o, .fuse_prog_o, .fuse_status_o);
  // ----
  // helpers
  // ----
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // f is {channel, shutdown, fuse, override}
  function automatic logic [7:0] ins_of(input logic [3:0] f, input logic [2:0] lo);
    return {f[3:1], 1'b0, f[0], lo};
  endfunction
  function automatic logic [1:0] st_exp(input logic b, input logic f);
    return f ? DOP_FUSE_FATAL : (b ? DOP_FUSE_DONE : DOP_FUSE_READY);
  endfunction
  task automatic wr(input logic [7:0] ins, input logic [15:0] dd, input int nd);
    logic a;
    m.start();
    m.put_byte({addr, 1'b0}, a);
    chk("addr ack", {7'h0, a}, 8'h01);
    m.put_byte(ins, a);
    chk("instr ack", {7'h0, a}, 8'h01);
    for (int i = 0; i < nd; i++) begin
      m.put_byte(dd[15 - 8 * i -: 8], a);
      chk("data ack", {7'h0, a}, 8'h01);
    end
    m.stop();
  endtask
  task automatic rd(input logic [7:0] w);
    logic a;
    logic [7:0] b;
    m.start();
    m.put_byte({addr, 1'b1}, a);
    chk("read ack", {7'h0, a}, 8'h01);
    m.get_byte(1'b1, b);
    chk("read wiper", b, w);
    m.get_byte(1'b1, b);
    chk("read status", b, {st_exp(fuse_blown_i, fuse_fault_i), 6'h00});
    m.get_byte(1'b0, b);
    chk("read again", b, w);
    m.stop();
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [7:0] e1, e2, d;
    logic ch, a;
    void'($urandom(38));
    e1 = DOP_WIPER_MID;
    e2 = DOP_WIPER_MID;
    @(negedge mclk_i);
    {addr_select_pin_high_i, addr_select_pin_low_i} = 2'($urandom);
    fused_wiper1_i = 8'($urandom);
    fused_wiper2_i = 8'($urandom);
    repeat (5) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    addr = {DOP_ADDR_FIXED_HI, addr_select_pin_high_i, addr_select_pin_low_i};
    repeat (8) @(negedge mclk_i);
    chk("wiper1 preset", wiper_setting1_o, e1);
    chk("wiper2 preset", wiper_setting2_o, e2);
    m.start();
    m.put_byte({addr ^ 7'h01, 1'b0}, a);
    chk("foreign ack", {7'h0, a}, 8'h00);
    m.put_byte(8'h00, a);
    m.put_byte(8'h5a, a);
    m.stop();
    for (int k = 0; k < 6; k++) begin
      ch = k < 2 ? k[0] : 1'($urandom);
      d = k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($urandom);
      wr(ins_of({ch, 3'h0}, 3'($urandom)), {~d, d}, 2);
      if (ch) e2 = d;
      else e1 = d;
      chk("wiper1", wiper_setting1_o, e1);
      chk("wiper2", wiper_setting2_o, e2);
      rd(d);
    end
    wr(ins_of(4'h0, 3'h5), 16'h0, 0);
    rd(e1);
    d = 8'($urandom);
    wr(ins_of(4'h4, 3'h0), {d, 8'h00}, 1);
    e1 = d;
    chk("shutdown on", {7'h0, shutdown_o}, 8'h01);
    chk("wiper in shutdown", wiper_setting1_o, e1);
    wr(ins_of(4'h0, 3'h0), 16'h0, 0);
    chk("shutdown off", {7'h0, shutdown_o}, 8'h00);
    wr(ins_of(4'h2, 3'h0), {e1, 8'h00}, 1);
    for (int n = 0; n < 1000 && !(seen_prog && !fuse_prog_o); n++) @(negedge mclk_i);
    chk("fuse programmed", {7'h0, seen_prog && !fuse_prog_o}, 8'h01);
    if (!(seen_prog && !fuse_prog_o)) summarize();
    fuse_blown_i = 1'b1;
    rd(e1);
    wr(ins_of(4'h0, 3'h0), {~e1, 8'h00}, 1);
    chk("frozen wiper", wiper_setting1_o, e1);
    wr(ins_of(4'h1, 3'h0), {~e1, 8'h00}, 1);
    chk("override wiper", wiper_setting1_o, ~e1);
    wr(ins_of(4'h0, 3'h0), 16'h0, 0);
    chk("override cleared", wiper_setting1_o, e1);
    wr(ins_of(4'hb, 3'h0), {8'h3c, 8'h00}, 1);
    sys_rst_i = 1'b1;
    repeat (5) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    repeat (8) @(negedge mclk_i);
    chk("wiper1 fused", wiper_setting1_o, fused_wiper1_i);
    chk("wiper2 fused", wiper_setting2_o, fused_wiper2_i);
    chk("status done", {6'h0, fuse_status_o}, {6'h0, st_exp(1'b1, 1'b0)});
    fuse_fault_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk("status fatal", {6'h0, fuse_status_o}, {6'h0, st_exp(1'b1, 1'b1)});
    summarize();
  end
endmodule
bind dop_pot_slave dop_pot_monitor #(.FUSE_CYCLES(FUSE_CYCLES)) mon (.mclk_i, .sys_rst_i,
  .scl_i, .sda_o, .sda_oe_o, .fuse_blown_i, .fuse_fault_i, .wiper_setting1_o,
  .wiper_setting2_o, .shutdown_o, .fuse_prog_o, .fuse_status_o);
`default_nettype wire
